// [pllc_clock_gen.sv]
`timescale 1ns/1ps
`default_nettype none
// Clock generator: reference path, PLL digital parts, base clock selector
module pllc_clock_gen #(
    parameter int LOCK_WIN  = pllc_pkg::LOCK_WINDOW,
    parameter int LOCK_TL   = pllc_pkg::LOCK_TOL,
    parameter int UNLOCK_TL = pllc_pkg::UNLOCK_TOL,
    parameter int TRACK_TL  = pllc_pkg::TRACK_TOL,
    parameter int UNTRACK_TL= pllc_pkg::UNTRACK_TOL
) (
    input  wire logic                    clk,
    input  wire logic                    rst_b,
    input  wire pllc_pkg::pllc_bus_req_t busReq,
    output logic [pllc_pkg::DATA_W-1:0]  rdData,
    input  wire logic                    oscillatorEnable,
    input  wire logic                    crystalAmpInput,
    input  wire logic                    vcoClock,
    output logic                         crystalAmpOutput,
    output logic                         crystalClock,
    output logic                         pllReferenceClock,
    output logic                         finalReferenceClock,
    output logic                         vcoFeedbackClock,
    output logic                         baseClockOut,
    output logic                         pumpUp,
    output logic                         pumpDown,
    output logic                         trackingMode,
    output logic                         pllLocked,
    output logic                         vcoEnable,
    output logic [31:0]                  vcoCentreHz,
    output logic                         clockGenInterrupt
);
    import pllc_pkg::*;

    localparam int CW = $clog2(LOCK_WIN) + 2;   // Counter width, room for overshoot

    // Parameter sanity
    if (LOCK_WIN < 2 || LOCK_TL > UNLOCK_TL || TRACK_TL > UNTRACK_TL || UNTRACK_TL >= LOCK_WIN)
    begin : gBadParams
        $error("pllc_clock_gen: unusable lock detector parameters");
    end

    // Register group
    logic [7:0]      ctl_q, ctl_d;          // Control register storage
    logic [7:0]      bw_q, bw_d;            // Bandwidth register storage
    logic [7:0]      prog_q, prog_d;        // Program register storage
    logic [ST_W-1:0] stat_q, stat_d;        // Sticky events
    logic [ST_W-1:0] mask_q, mask_d;        // Interrupt mask
    logic [7:0]      rdData_q, rdData_d;
    logic            irq_q, irq_d;
    logic [31:0]     centre_q, centre_d;
    // Clock path group
    logic            xtal_q, xtal_d;        // Gated crystal clock
    logic            ref_q, ref_d;          // Buffered reference
    logic            fref_q, fref_d;        // Final reference
    logic            vco_q, vco_d;          // Gated VCO level
    logic            xtalOut_q, xtalOut_d;  // Amplifier output
    logic            vcoEn_q, vcoEn_d;
    // Selector group
    pllc_sel_state_t sel_q, sel_d;
    logic [1:0]      eCnt_q, eCnt_d;        // Edges seen in the current wait
    logic            useVco_q, useVco_d;    // Source now driving base clock
    logic            base_q, base_d;
    // Phase and lock group
    logic            up_q, up_d, dn_q, dn_d;
    logic [CW-1:0]   refCnt_q, refCnt_d, fbCnt_q, fbCnt_d;
    logic            lockDet_q, lockDet_d, trkDet_q, trkDet_d;
    logic            lockBit_q, lockBit_d, trkBit_q, trkBit_d;

    // Shared decodes
    logic            pllRun, wantVco, xtalRise, vcoRise, refRise, fbRise, fbClk, isWr;
    logic [CW-1:0]   diff;

    // Address match on a write strobe
    function automatic logic wrHit(input pllc_bus_req_t r, input logic [7:0] a);
        wrHit = r.wrStb && (r.addr == a);
    endfunction : wrHit

    assign pllRun   = ctl_q[CTL_ON_BIT] && (prog_q[PROG_L_LSB +: FIELD_W] != '0);
    assign wantVco  = ctl_q[CTL_BCS_BIT] && pllRun;
    assign xtalRise = xtal_d && !xtal_q;
    assign vcoRise  = vco_d && !vco_q;
    assign refRise  = fref_d && !fref_q;
    assign isWr     = busReq.wrStb;

    // Feedback divider on the VCO edges
    pllc_mod_div #(
        .W         (FIELD_W)
    ) uFbDiv (
        .clk       (clk),
        .rst_b     (rst_b),
        .srcLevel  (vco_q),
        .srcRise   (vcoRise),
        .modulus   (prog_q[PROG_N_LSB +: FIELD_W]),
        .divClk_q  (fbClk),
        .divRise_q (fbRise)
    );

    // Clock path next values
    always_comb
    begin
        xtal_d    = oscillatorEnable && crystalAmpInput;
        xtalOut_d = oscillatorEnable && !crystalAmpInput;
        ref_d     = xtal_q;
        fref_d    = ref_q;
        vcoEn_d   = pllRun;
        vco_d     = vcoClock && pllRun;
    end

    // Clock path registers
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            xtal_q    <= 1'b0;
            xtalOut_q <= 1'b0;
            ref_q     <= 1'b0;
            fref_q    <= 1'b0;
            vcoEn_q   <= 1'b0;
            vco_q     <= 1'b0;
        end
        else
        begin
            xtal_q    <= xtal_d;
            xtalOut_q <= xtalOut_d;
            ref_q     <= ref_d;
            fref_q    <= fref_d;
            vcoEn_q   <= vcoEn_d;
            vco_q     <= vco_d;
        end
    end

    // Base clock selector next values
    always_comb
    begin
        sel_d    = sel_q;
        eCnt_d   = eCnt_q;
        useVco_d = useVco_q;
        base_d   = base_q;
        unique case (sel_q)
            SEL_RUN:
            begin
                // Halve the active source on its rising edge
                if (useVco_q ? vcoRise : xtalRise)
                    base_d = !base_q;
                if (wantVco != useVco_q)
                begin
                    sel_d  = SEL_WAIT_OLD;
                    eCnt_d = '0;
                end
            end
            SEL_WAIT_OLD:
            begin
                // Output held; a stopped old source is not waited for
                if (wantVco == useVco_q)
                    sel_d = SEL_RUN;
                else if (eCnt_q == SWITCH_EDGES || (useVco_q ? !pllRun : !oscillatorEnable))
                begin
                    sel_d  = SEL_WAIT_NEW;
                    eCnt_d = '0;
                end
                else if (useVco_q ? vcoRise : xtalRise)
                    eCnt_d = eCnt_q + 2'h1;
            end
            SEL_WAIT_NEW:
            begin
                if (wantVco == useVco_q)
                    sel_d = SEL_RUN;
                else if (eCnt_q == SWITCH_EDGES)
                begin
                    sel_d    = SEL_RUN;
                    useVco_d = wantVco;
                end
                else if (wantVco ? vcoRise : xtalRise)
                    eCnt_d = eCnt_q + 2'h1;
            end
            default:
                sel_d = SEL_RUN;                           // Unused code
        endcase
    end

    // Base clock selector registers
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sel_q    <= SEL_RUN;
            eCnt_q   <= '0;
            useVco_q <= 1'b0;
            base_q   <= 1'b0;
        end
        else
        begin
            sel_q    <= sel_d;
            eCnt_q   <= eCnt_d;
            useVco_q <= useVco_d;
            base_q   <= base_d;
        end
    end

    // Phase detector and lock detector next values
    always_comb
    begin
        // Tri-state style detector: both up means reset both
        if (up_q && dn_q)
        begin
            up_d = 1'b0;
            dn_d = 1'b0;
        end
        else
        begin
            up_d = (up_q || refRise) && pllRun;
            dn_d = (dn_q || fbRise) && pllRun;
        end
        refCnt_d  = refCnt_q;
        fbCnt_d   = (fbRise && !(&fbCnt_q)) ? fbCnt_q + CW'(1) : fbCnt_q;
        lockDet_d = lockDet_q;
        trkDet_d  = trkDet_q;
        diff      = (fbCnt_q > CW'(LOCK_WIN)) ? fbCnt_q - CW'(LOCK_WIN) : CW'(LOCK_WIN) - fbCnt_q;
        // Compare feedback edges against a window of reference edges
        if (refRise)
        begin
            if (refCnt_q == CW'(LOCK_WIN - 1))
            begin
                refCnt_d = '0;
                fbCnt_d  = '0;
                if (diff <= CW'(LOCK_TL))
                    lockDet_d = 1'b1;
                else if (diff > CW'(UNLOCK_TL))
                    lockDet_d = 1'b0;
                if (diff <= CW'(TRACK_TL))
                    trkDet_d = 1'b1;
                else if (diff > CW'(UNTRACK_TL))
                    trkDet_d = 1'b0;
            end
            else
                refCnt_d = refCnt_q + CW'(1);
        end
        if (!pllRun)
        begin
            refCnt_d  = '0;
            fbCnt_d   = '0;
            lockDet_d = 1'b0;
            trkDet_d  = 1'b0;
        end
        // Manual mode: lock bit disabled, filter follows software
        lockBit_d = bw_q[BW_AUTO_BIT] && lockDet_d;
        trkBit_d  = bw_q[BW_AUTO_BIT] ? trkDet_d : bw_q[BW_ACQ_BIT];
    end

    // Phase detector and lock detector registers
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            up_q      <= 1'b0;
            dn_q      <= 1'b0;
            refCnt_q  <= '0;
            fbCnt_q   <= '0;
            lockDet_q <= 1'b0;
            trkDet_q  <= 1'b0;
            lockBit_q <= 1'b0;
            trkBit_q  <= 1'b0;
        end
        else
        begin
            up_q      <= up_d;
            dn_q      <= dn_d;
            refCnt_q  <= refCnt_d;
            fbCnt_q   <= fbCnt_d;
            lockDet_q <= lockDet_d;
            trkDet_q  <= trkDet_d;
            lockBit_q <= lockBit_d;
            trkBit_q  <= trkBit_d;
        end
    end

    // Register file next values
    always_comb
    begin
        logic [ST_W-1:0] ev;
        ev       = '0;
        ctl_d    = ctl_q;
        bw_d     = bw_q;
        prog_d   = prog_q;
        mask_d   = mask_q;
        rdData_d = '0;
        if (wrHit(busReq, PLL_CONTROL_ADDR))
        begin
            ctl_d[CTL_ON_BIT]  = busReq.wrData[CTL_ON_BIT];
            ctl_d[CTL_BCS_BIT] = busReq.wrData[CTL_BCS_BIT];
        end
        if (wrHit(busReq, PLL_BANDWIDTH_CONTROL_ADDR))
        begin
            bw_d[BW_AUTO_BIT] = busReq.wrData[BW_AUTO_BIT];
            bw_d[BW_ACQ_BIT]  = busReq.wrData[BW_ACQ_BIT]; // Steers filter only in manual mode
        end
        if (wrHit(busReq, PLL_MULTIPLIER_PROGRAM_ADDR))
            prog_d = busReq.wrData;
        if (wrHit(busReq, IRQ_MASK_ADDR))
            mask_d = busReq.wrData[ST_W-1:0];
        // Events: lock change in automatic mode, completed source switch
        ev[ST_LOCK_BIT]   = bw_q[BW_AUTO_BIT] && (lockBit_d != lockBit_q);
        ev[ST_SWITCH_BIT] = (sel_q == SEL_WAIT_NEW) && (sel_d == SEL_RUN) && (useVco_d != useVco_q);
        // Write-one-to-clear; a new event wins over the clear
        stat_d = stat_q;
        if (wrHit(busReq, IRQ_STATUS_ADDR))
            stat_d = stat_q & ~busReq.wrData[ST_W-1:0];
        stat_d = stat_d | ev;
        irq_d  = |(stat_d & mask_d);
        centre_d = 32'(prog_d[PROG_L_LSB +: FIELD_W]) * NOM_CENTRE_HZ;
        // Read mux, data valid in the following cycle only
        if (busReq.rdStb && !isWr)
        begin
            unique case (busReq.addr)
                PLL_CONTROL_ADDR:
                begin
                    rdData_d                = ctl_q;
                    rdData_d[CTL_FLAG_BIT]  = stat_q[ST_LOCK_BIT];
                    rdData_d[CTL_VSEL_BIT]  = useVco_q;
                end
                PLL_BANDWIDTH_CONTROL_ADDR:
                begin
                    rdData_d               = bw_q;
                    rdData_d[BW_LOCK_BIT]  = lockBit_q;
                    rdData_d[BW_ACQ_BIT]   = trkBit_q;
                end
                PLL_MULTIPLIER_PROGRAM_ADDR: rdData_d = prog_q;
                IRQ_STATUS_ADDR:             rdData_d = 8'(stat_q);
                IRQ_MASK_ADDR:               rdData_d = 8'(mask_q);
                default:                     rdData_d = 8'h00; // Unmapped reads zero
            endcase
        end
    end

    // Register file registers
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ctl_q    <= CTL_RESET;
            bw_q     <= BW_RESET;
            prog_q   <= PROG_RESET;
            stat_q   <= '0;
            mask_q   <= MASK_RESET;
            rdData_q <= 8'h00;
            irq_q    <= 1'b0;
            centre_q <= 32'h0000_0000;
        end
        else
        begin
            ctl_q    <= ctl_d;
            bw_q     <= bw_d;
            prog_q   <= prog_d;
            stat_q   <= stat_d;
            mask_q   <= mask_d;
            rdData_q <= rdData_d;
            irq_q    <= irq_d;
            centre_q <= centre_d;
        end
    end

    // Outputs, all from flip-flops
    assign rdData              = rdData_q;
    assign crystalAmpOutput    = xtalOut_q;
    assign crystalClock        = xtal_q;
    assign pllReferenceClock   = ref_q;
    assign finalReferenceClock = fref_q;
    assign vcoFeedbackClock    = fbClk;
    assign baseClockOut        = base_q;
    assign pumpUp              = up_q;
    assign pumpDown            = dn_q;
    assign trackingMode        = trkBit_q;
    assign pllLocked           = lockBit_q;
    assign vcoEnable           = vcoEn_q;
    assign vcoCentreHz         = centre_q;
    assign clockGenInterrupt   = irq_q;
endmodule : pllc_clock_gen
`default_nettype wire

// [pllc_clock_gen_props.sv]
`timescale 1ns/1ps
`default_nettype none
// Port-level checks kept beside the clock generator
module pllc_clock_gen_props (
    input wire logic                    clk,
    input wire logic                    rst_b,
    input wire pllc_pkg::pllc_bus_req_t busReq,
    input wire logic [7:0]              rdData,
    input wire logic                    oscillatorEnable,
    input wire logic                    crystalAmpInput,
    input wire logic                    crystalAmpOutput,
    input wire logic                    crystalClock,
    input wire logic                    pllReferenceClock,
    input wire logic                    finalReferenceClock,
    input wire logic                    pumpUp,
    input wire logic                    pumpDown,
    input wire logic [31:0]             vcoCentreHz
);
    import pllc_pkg::*;
    logic [1:0] live_q;   // Edges since reset, saturating
    logic [1:0] live_d;
    logic       live;     // History seen by $past is all post-reset
    // Count to three so no check looks back into reset
    always_comb
    begin
        live_d = (live_q == 2'h3) ? live_q : live_q + 2'h1;
    end
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            live_q <= 2'h0;
        else
            live_q <= live_d;
    end
    assign live = (live_q == 2'h3);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // Enable seen low at two edges in a row
    sequence s_oscOff;
        !oscillatorEnable ##1 !oscillatorEnable;
    endsequence
    a_osc_gate: assert property (s_oscOff |-> !crystalClock && !crystalAmpOutput)
        else $error("crystal path active while disabled");
    a_xtal_follow: assert property (live && $past(oscillatorEnable) |-> crystalClock == $past(crystalAmpInput))
        else $error("crystal clock does not follow input");
    a_ref_buffer: assert property (live |-> pllReferenceClock == $past(crystalClock))
        else $error("reference is not the buffered crystal");
    a_final_ref: assert property (live |-> finalReferenceClock == $past(crystalClock, 2))
        else $error("final reference divided or skewed");
    a_pump_pair: assert property (pumpUp && pumpDown |=> !pumpUp && !pumpDown)
        else $error("pump pulses not cleared together");
    a_rd_idle: assert property (live && !$past(busReq.rdStb) |-> rdData == 8'h00)
        else $error("read data without a read");
    a_centre_step: assert property (vcoCentreHz % NOM_CENTRE_HZ == 32'h00000000)
        else $error("centre not a multiple of nominal");
    a_centre_max: assert property (vcoCentreHz <= 32'h04650000)
        else $error("centre above fifteen times nominal");
endmodule : pllc_clock_gen_props
bind pllc_clock_gen pllc_clock_gen_props u_props (.clk(clk), .rst_b(rst_b), .busReq(busReq), .rdData(rdData),
    .oscillatorEnable(oscillatorEnable), .crystalAmpInput(crystalAmpInput), .crystalAmpOutput(crystalAmpOutput),
    .crystalClock(crystalClock), .pllReferenceClock(pllReferenceClock), .finalReferenceClock(finalReferenceClock),
    .pumpUp(pumpUp), .pumpDown(pumpDown), .vcoCentreHz(vcoCentreHz));
`default_nettype wire

// [pllc_mod_div.sv]
`timescale 1ns/1ps
`default_nettype none
// Modulo divider: one output edge train per N input rising edges
module pllc_mod_div #(
    parameter int W = 4
) (
    input  wire logic         clk,
    input  wire logic         rst_b,
    input  wire logic         srcLevel,   // Sampled source clock level
    input  wire logic         srcRise,    // Source rising edge, one cycle
    input  wire logic [W-1:0] modulus,    // Divide factor; zero acts as one
    output logic              divClk_q,   // Divided clock level
    output logic              divRise_q   // Divided clock rising edge, one cycle
);
    logic [W-1:0] cnt_q, cnt_d;           // Source edges since last wrap
    logic [W-1:0] modEff;                 // Effective modulus
    logic         divClk_d, divRise_d;

    // Next count and divided level
    always_comb
    begin
        modEff    = (modulus == '0) ? W'(1) : modulus;
        cnt_d     = cnt_q;
        divRise_d = 1'b0;
        if (srcRise)
        begin
            cnt_d     = (cnt_q >= modEff - W'(1)) ? '0 : cnt_q + W'(1);
            divRise_d = (cnt_d == '0);
        end
        // Divide by one follows the source itself, else high for the first half
        if (modEff == W'(1))
            divClk_d = srcLevel;
        else
            divClk_d = ({1'b0, cnt_d} < (({1'b0, modEff} + (W+1)'(1)) >> 1)); // Widened: top modulus must not wrap
    end

    // State registers
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cnt_q     <= '0;
            divClk_q  <= 1'b0;
            divRise_q <= 1'b0;
        end
        else
        begin
            cnt_q     <= cnt_d;
            divClk_q  <= divClk_d;
            divRise_q <= divRise_d;
        end
    end
endmodule : pllc_mod_div
`default_nettype wire

// [pllc_osc_model.sv]
`timescale 1ns/1ps
`default_nettype none
// External clock on the amplifier input plus a behavioural VCO
module pllc_osc_model #(
    parameter int XTAL_HALF = 12,  // Crystal half period in clk cycles
    parameter int VCO_HALF  = 4    // VCO half period, three times the crystal rate
) (
    input  wire logic clk,
    input  wire logic vcoRun,      // VCO powered by the device
    output var logic  xtalLevel,
    output var logic  vcoLevel
);
    int xCnt = 0;                  // Crystal phase counter
    int vCnt = 0;                  // VCO phase counter
    initial
    begin
        xtalLevel = 1'b0;
        vcoLevel  = 1'b0;
    end
    // Canned source runs free, so any gating must come from the device
    always @(posedge clk)
    begin
        xCnt <= (xCnt == XTAL_HALF - 1) ? 0 : xCnt + 1;
        if (xCnt == XTAL_HALF - 1)
            xtalLevel <= ~xtalLevel;
        vCnt <= (!vcoRun || vCnt == VCO_HALF - 1) ? 0 : vCnt + 1;
        // Unpowered VCO stands still low
        if (!vcoRun)
            vcoLevel <= 1'b0;
        else if (vCnt == VCO_HALF - 1)
            vcoLevel <= ~vcoLevel;
    end
endmodule : pllc_osc_model
`default_nettype wire

// [pllc_pkg.sv]
// Summary of operation
// - Base clock is halved crystal or VCO
// - Crystal clock buffered into PLL reference
// - Crystal runs only while oscillator enabled
// - VCO divided modulo N for feedback
// - Final reference equals PLL reference frequency
// - Phase detector emits directional correction pulses
// - Lock detector sets filter mode, lock
// - Interrupt on entering or leaving lock
// - Acquisition/tracking switched automatically or manually
// - Registers decode at 0x1C, 0x1D, 0x1E
// - VCO centre equals L times 4.9152 MHz
// - Program register: N upper, L lower
// - N of zero acts as one
// - L of zero disables PLL selection
// - Switch waits three edges per source
`default_nettype none
package pllc_pkg;
    localparam int ADDR_W = 8;                              // Register address width
    localparam int DATA_W = 8;                              // Register data width
    // Register offsets
    localparam logic [7:0] PLL_CONTROL_ADDR            = 8'h1C;
    localparam logic [7:0] PLL_BANDWIDTH_CONTROL_ADDR  = 8'h1D;
    localparam logic [7:0] PLL_MULTIPLIER_PROGRAM_ADDR = 8'h1E;
    localparam logic [7:0] IRQ_STATUS_ADDR             = 8'h20;
    localparam logic [7:0] IRQ_MASK_ADDR               = 8'h21;
    // Control register fields
    localparam int CTL_FLAG_BIT   = 6;                      // Pending lock-change event, read only
    localparam int CTL_ON_BIT     = 5;                      // PLL on
    localparam int CTL_BCS_BIT    = 4;                      // Base clock select request
    localparam int CTL_VSEL_BIT   = 3;                      // VCO actually driving base clock, read only
    // Bandwidth control fields
    localparam int BW_AUTO_BIT    = 7;                      // Automatic bandwidth control
    localparam int BW_LOCK_BIT    = 6;                      // Lock indicator, read only
    localparam int BW_ACQ_BIT     = 5;                      // 1 = tracking, 0 = acquisition
    // Program register fields
    localparam int PROG_N_LSB     = 4;
    localparam int PROG_L_LSB     = 0;
    localparam int FIELD_W        = 4;
    // Interrupt status and mask fields
    localparam int ST_LOCK_BIT    = 0;                      // Lock state changed
    localparam int ST_SWITCH_BIT  = 1;                      // Base clock source switch completed
    localparam int ST_W           = 2;
    // Reset values
    localparam logic [7:0] CTL_RESET  = 8'h00;
    localparam logic [7:0] BW_RESET   = 8'h00;
    localparam logic [7:0] PROG_RESET = 8'h00;
    localparam logic [ST_W-1:0] MASK_RESET = 2'h0;
    // Nominal VCO centre frequency in Hz
    localparam logic [31:0] NOM_CENTRE_HZ = 32'h004B0000;
    // Lock detector defaults: window in reference edges, tolerances in feedback edges
    localparam int LOCK_WINDOW = 16;
    localparam int LOCK_TOL    = 1;
    localparam int UNLOCK_TOL  = 2;
    localparam int TRACK_TOL   = 2;
    localparam int UNTRACK_TOL = 4;
    // Edges of each source waited on a base clock change
    localparam logic [1:0] SWITCH_EDGES = 2'h3;

    // Register port request
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wrData;
        logic              wrStb;
        logic              rdStb;
    } pllc_bus_req_t;

    // Base clock selector states, Gray coded from SEL_RUN to SEL_WAIT_NEW; the return to SEL_RUN flips both bits
    typedef enum logic [1:0] {
        SEL_RUN      = 2'b00,
        SEL_WAIT_OLD = 2'b01,
        SEL_WAIT_NEW = 2'b11
    } pllc_sel_state_t;
endpackage : pllc_pkg
`default_nettype wire

// [testbench.sv]
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench for the clock generator
module testbench;
    import pllc_pkg::*;
    typedef struct {logic [7:0] a, d, e;} pllc_row_t;
    logic          clk = 1'b0;    // 200 MHz
    logic          rst_b = 1'b0;
    pllc_bus_req_t req = '0;      // Register request
    logic          osc = 1'b1;    // Oscillator enable
    logic [7:0]    rdData;
    logic          xtal, vco, fbClk, refFin, baseClk, track, locked, vcoOn, irq;
    logic [31:0]   centreHz;
    logic [4:0]    mon;           // Clocks seen by the edge counter
    int            cnt[5];
    int            err_count = 0;
    int            checks_done = 0;
    // Write, then expected read-back; RO bits and unmapped space drop writes
    pllc_row_t rows[6] = '{'{8'h1E, 8'hA7, 8'hA7}, '{8'h21, 8'h03, 8'h03}, '{8'h21, 8'hFC, 8'h00},
        '{8'h1D, 8'h20, 8'h20}, '{8'h3F, 8'hFF, 8'h00}, '{8'h1C, 8'h48, 8'h00}};
    assign mon = {baseClk, fbClk, vco, refFin, xtal};
    always #2.5 clk = ~clk;
    pllc_osc_model u_osc (.clk(clk), .vcoRun(vcoOn), .xtalLevel(xtal), .vcoLevel(vco));
    pllc_clock_gen DUT (.clk(clk), .rst_b(rst_b), .busReq(req), .rdData(rdData), .oscillatorEnable(osc),
        .crystalAmpInput(xtal), .vcoClock(vco), .crystalAmpOutput(), .crystalClock(), .pllReferenceClock(),
        .finalReferenceClock(refFin), .vcoFeedbackClock(fbClk), .baseClockOut(baseClk), .pumpUp(), .pumpDown(),
        .trackingMode(track), .pllLocked(locked), .vcoEnable(vcoOn), .vcoCentreHz(centreHz),
        .clockGenInterrupt(irq));
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            err_count++;
            $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : cmp
    function automatic logic near(input int a, input int b, input int tol);
        return (a - b <= tol) && (b - a <= tol);
    endfunction : near
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : settle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{addr: a, wrData: d, wrStb: 1'b1, rdStb: 1'b0};
        @(posedge clk);
        req.wrStb <= 1'b0;
    endtask : wr
    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        req <= '{addr: a, wrData: 8'h00, wrStb: 1'b0, rdStb: 1'b1};
        @(posedge clk);
        req.rdStb <= 1'b0;
        #1;
        cmp(rdData, e);
    endtask : rd
    // Rising edges of each watched clock over n cycles
    task automatic count(input int n);
        logic [4:0] prev;
        prev = mon;
        cnt = '{default: 0};
        repeat (n)
        begin
            settle(1);
            for (int i = 0; i < 5; i++)
                if (mon[i] && !prev[i])
                    cnt[i]++;
            prev = mon;
        end
    endtask : count
    // Bounded wait on lock or on the interrupt line
    task automatic waitv(input logic v, input bit useIrq);
        repeat (4000)
        begin
            settle(1);
            if ((useIrq ? irq : locked) === v)
                break;
        end
        cmp(useIrq ? irq : locked, v);
    endtask : waitv
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : test_done
    initial
    begin
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        for (int a = 8'h1C; a <= 8'h21; a++)
            rd(8'(a), 8'h00);
        foreach (rows[i])
        begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a, rows[i].e);
        end
        wr(8'h1D, 8'h00);
        $display("test registers done");
        wr(8'h1C, 8'h20);
        for (int l = 0; l < 16; l++)
        begin
            wr(8'h1E, {4'h1, 4'(l)});
            settle(3);
            cmp(centreHz, 32'(l) * NOM_CENTRE_HZ);
            cmp(vcoOn, l != 0);
        end
        // L of zero: the VCO request never takes effect
        wr(8'h1E, 8'h00);
        wr(8'h1C, 8'h30);
        settle(200);
        rd(8'h1C, 8'h30);
        wr(8'h1C, 8'h00);
        osc <= 1'b0;
        settle(3);
        count(200);
        cmp(cnt[1], 0);
        @(posedge clk);
        osc <= 1'b1;
        count(480);
        cmp(near(cnt[1], cnt[0], 1), 1'b1);
        cmp(near(cnt[4] * 2, cnt[0], 2), 1'b1);
        $display("test crystal path done");
        wr(8'h1E, 8'h31);
        wr(8'h1D, 8'h80);
        wr(8'h1C, 8'h20);
        waitv(1'b1, 1'b0);
        cmp(track, 1'b1);
        count(480);
        cmp(near(cnt[3] * 3, cnt[2], 3), 1'b1);
        wr(8'h21, 8'h01);
        settle(2);
        cmp(irq, 1'b1);
        rd(8'h20, 8'h01);
        wr(8'h20, 8'h01);
        settle(2);
        cmp(irq, 1'b0);
        $display("test lock done");
        wr(8'h21, 8'h02);
        wr(8'h1C, 8'h30);
        waitv(1'b1, 1'b1);
        rd(8'h1C, 8'h38);
        count(480);
        cmp(near(cnt[4] * 2, cnt[2], 2), 1'b1);
        wr(8'h1E, 8'h01);
        count(240);
        cmp(near(cnt[3], cnt[2], 1), 1'b1);
        waitv(1'b0, 1'b0);
        rd(8'h20, 8'h03);
        $display("test switch done");
        @(posedge clk);
        rst_b <= 1'b0;
        settle(2);
        cmp({baseClk, irq, locked, vcoOn}, 4'h0);
        @(posedge clk);
        rst_b <= 1'b1;
        rd(8'h1C, 8'h00);
        $display("test reset done");
        test_done();
    end
    // Hang guard, well beyond the expected run
    initial
    begin
        repeat (60000) @(posedge clk);
        err_count++;
        $display("mismatch at %0t: watchdog expired", $time);
        test_done();
    end
endmodule : testbench
`default_nettype wire
